// file: pkg/ssef_pkg.sv
// constants shared by the serial port control block
package ssef_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_BUFFER = 8'h13;
  localparam logic [7:0] ADDR_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h15;
  localparam logic [7:0] ADDR_MASK = 8'h16;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BIT_WRITE_COLLISION_FLAG = 7;
  localparam int BIT_OV = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_CKP = 4;
  localparam int MODE_MSB = 3;
  localparam logic [3:0] MODE_SLAVE_LO = 4'h4;
  localparam logic [3:0] MODE_I2C_LO = 4'h6;
  localparam int EV_DONE = 0;
  localparam int EV_OV = 1;
  localparam int EV_WRITE_COLLISION_FLAG = 2;
  localparam int EV_W = 3;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_HALF_NS = 160;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ssef_pkg

// file: src/ssef_port.sv
// serial port with control register, write collision and receive overflow flags
// How it works
// - 8-bit control at 14h, reset zero
// - slave overflow: flag set, new byte dropped
// - spi overflow only raised as slave
// - master never sets receive overflow flag
// - i2c byte onto full buffer sets overflow
// - overflow stays until software writes it clear
// - enable gives both pins to port as master, only sdo as spi slave, none in i2c modes, else released
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ssef_port #(
  parameter int HALF_CYCLES = ssef_pkg::SCK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ssef_pkg::ADDR_W-1:0] addr,
  input wire logic [ssef_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ssef_pkg::DATA_W-1:0] rdata,
  output logic irq,
  input wire logic sck_in,
  input wire logic sdi,
  output logic sck_out,
  output logic sck_oe,
  output logic sdo,
  output logic sdo_oe
);

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic [7:0] ctrl;
    logic [7:0] buffer;
    logic buf_full;
    logic [7:0] shift;
    logic latch;
    logic [3:0] bit_cnt;
    logic busy;
    logic [7:0] half_cnt;
    logic sck;
    logic sck_oe;
    logic sck_pin;
    logic sdo;
    logic sdo_oe;
    logic [ssef_pkg::EV_W-1:0] status;
    logic [ssef_pkg::EV_W-1:0] mask;
    logic irq;
    logic [7:0] rdata;
  } ssef_state_t;

  function automatic logic ssef_is_master(input logic [3:0] m);
    return m < ssef_pkg::MODE_SLAVE_LO;
  endfunction : ssef_is_master

  function automatic logic ssef_is_i2c(input logic [3:0] m);
    return m >= ssef_pkg::MODE_I2C_LO;
  endfunction : ssef_is_i2c

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  logic rst_s1;
  logic rst_ok;
  ssef_state_t q;
  ssef_state_t d;
  logic lead;
  logic trail;
  logic done;
  logic master;
  logic i2c;
  logic en;
  logic idle;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_ok <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_ok <= rst_s1;
    end
  end

  always_comb begin
    d = q;
    master = ssef_is_master(q.ctrl[ssef_pkg::MODE_MSB:0]);
    i2c = ssef_is_i2c(q.ctrl[ssef_pkg::MODE_MSB:0]);
    en = q.ctrl[ssef_pkg::BIT_EN];
    idle = q.ctrl[ssef_pkg::BIT_CKP];
    lead = 1'b0;
    trail = 1'b0;
    done = 1'b0;
    d.sck_s1 = sck_in;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.sdi_s1 = sdi;
    d.sdi_s2 = q.sdi_s1;
    d.rdata = 8'h00;
    // register reads, one cycle later
    if (rd) begin
      if (addr == ssef_pkg::ADDR_BUFFER) begin
        d.rdata = q.buffer;
        d.buf_full = 1'b0;
      end else if (addr == ssef_pkg::ADDR_CONTROL) begin
        d.rdata = q.ctrl;
      end else if (addr == ssef_pkg::ADDR_STATUS) begin
        d.rdata = {5'h00, q.status};
        d.status = '0;
      end else if (addr == ssef_pkg::ADDR_MASK) begin
        d.rdata = {5'h00, q.mask};
      end
    end
    // register writes
    if (wr) begin
      if (addr == ssef_pkg::ADDR_CONTROL) begin
        d.ctrl = wdata;
      end else if (addr == ssef_pkg::ADDR_MASK) begin
        d.mask = wdata[ssef_pkg::EV_W-1:0];
      end else if (addr == ssef_pkg::ADDR_BUFFER) begin
        if (q.busy || q.bit_cnt != 4'h0) begin
          d.ctrl[ssef_pkg::BIT_WRITE_COLLISION_FLAG] = 1'b1;
          d.status[ssef_pkg::EV_WRITE_COLLISION_FLAG] = 1'b1;
        end else begin
          d.shift = wdata;
          d.busy = master && en;
          d.half_cnt = 8'h00;
        end
      end
    end
    // clock edges: generated as master, sampled as slave
    if (!en) begin
      d.busy = 1'b0;
      d.bit_cnt = 4'h0;
      d.half_cnt = 8'h00;
      d.sck = idle;
    end else if (master) begin
      if (q.busy) begin
        if (q.half_cnt == HALF_LAST) begin
          d.half_cnt = 8'h00;
          d.sck = !q.sck;
          lead = (q.sck == idle);
          trail = (q.sck != idle);
        end else begin
          d.half_cnt = q.half_cnt + 8'h01;
        end
      end else begin
        d.sck = idle;
      end
    end else begin
      lead = (q.sck_s2 != q.sck_s3) && (q.sck_s2 != idle);
      trail = (q.sck_s2 != q.sck_s3) && (q.sck_s2 == idle);
    end
    if (lead) begin
      d.latch = q.sdi_s2;
    end
    if (trail) begin
      d.shift = {q.shift[6:0], q.latch};
      d.bit_cnt = q.bit_cnt + 4'h1;
      if (q.bit_cnt == ssef_pkg::LAST_BIT) begin
        done = 1'b1;
        d.bit_cnt = 4'h0;
        d.busy = 1'b0;
      end
    end
    // byte complete: store or flag overflow
    if (done) begin
      d.status[ssef_pkg::EV_DONE] = 1'b1;
      if (q.buf_full && !master) begin
        d.ctrl[ssef_pkg::BIT_OV] = 1'b1;
        d.status[ssef_pkg::EV_OV] = 1'b1;
      end else begin
        d.buffer = {q.shift[6:0], q.latch};
        d.buf_full = 1'b1;
      end
    end
    d.sck_oe = d.ctrl[ssef_pkg::BIT_EN] && ssef_is_master(d.ctrl[ssef_pkg::MODE_MSB:0]);
    d.sdo_oe = d.ctrl[ssef_pkg::BIT_EN] && !ssef_is_i2c(d.ctrl[ssef_pkg::MODE_MSB:0]);
    d.sdo = d.sdo_oe ? d.shift[7] : 1'b0;
    d.sck_pin = d.sck_oe && d.sck;
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge clock or negedge rst_ok) begin
    if (!rst_ok) begin
      q <= '0;
      q.ctrl <= ssef_pkg::CONTROL_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq = q.irq;
  assign sck_out = q.sck_pin;
  assign sck_oe = q.sck_oe;
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;

  a_ctrl_write: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && wr && addr == ssef_pkg::ADDR_CONTROL |=> q.ctrl[5:0] == $past(wdata[5:0]))
    else $error("control write not stored");
  a_ov_slave_set: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && done && q.buf_full && !master |=> q.ctrl[ssef_pkg::BIT_OV] && $stable(q.buffer))
    else $error("overflow not flagged or buffer changed");
  a_ov_spi_slave: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && !i2c && !q.ctrl[ssef_pkg::BIT_OV] && !(wr && addr == ssef_pkg::ADDR_CONTROL)
    |=> !q.ctrl[ssef_pkg::BIT_OV] || ($past(done) && !$past(master)))
    else $error("spi overflow raised outside slave mode");
  a_ov_master_never: assert property (@(posedge clock) disable iff (!rst_ok)
    master && !q.ctrl[ssef_pkg::BIT_OV] && !(wr && addr == ssef_pkg::ADDR_CONTROL)
    |=> !q.ctrl[ssef_pkg::BIT_OV])
    else $error("master set overflow");
  a_ov_i2c_set: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && i2c && done && q.buf_full |=> q.status[ssef_pkg::EV_OV] && q.ctrl[ssef_pkg::BIT_OV])
    else $error("i2c overflow missed");
  a_ov_sticky: assert property (@(posedge clock) disable iff (!rst_ok)
    q.ctrl[ssef_pkg::BIT_OV] && !(ce && wr && addr == ssef_pkg::ADDR_CONTROL)
    |=> q.ctrl[ssef_pkg::BIT_OV])
    else $error("overflow cleared by hardware");
  a_write_collision_flag_set: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && wr && addr == ssef_pkg::ADDR_BUFFER && q.busy |=> q.ctrl[ssef_pkg::BIT_WRITE_COLLISION_FLAG]
    && q.status[ssef_pkg::EV_WRITE_COLLISION_FLAG])
    else $error("collision not flagged");
  a_pins_off: assert property (@(posedge clock) disable iff (!rst_ok)
    !q.ctrl[ssef_pkg::BIT_EN] && !(ce && wr) |=> !sck_oe && !sdo_oe && !sdo && !sck_out)
    else $error("pins driven while disabled");
  a_irq_level: assert property (@(posedge clock) disable iff (!rst_ok)
    irq == |(q.status & q.mask))
    else $error("interrupt level wrong");
  a_read_ctrl: assert property (@(posedge clock) disable iff (!rst_ok)
    ce && rd && addr == ssef_pkg::ADDR_CONTROL |=> rdata == $past(q.ctrl))
    else $error("control read data wrong");

endmodule : ssef_port

// file: bench/ssef_peer.sv
// far-side spi master model that clocks bytes into the slave port
`timescale 1ns/1ps
module ssef_peer (
  output logic sck,
  output logic sdi,
  input logic sdo
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end
  // clock stands at idle between frames, msb first, sdi flips when released
  task send(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #160 sck = 1'b1;
      r[i] = sdo;
      #160 sck = 1'b0;
    end
    sdi = ~b[0];
  endtask : send
endmodule : ssef_peer

// file: bench/ssef_port_test.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module ssef_port_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic irq, sck_in, sdi, sck_out, sck_oe, sdo, sdo_oe;
  logic [7:0] expq[$];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clock = ~clock;
  ssef_port uut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .sck_in(sck_in), .sdi(sdi), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdo(sdo), .sdo_oe(sdo_oe));
  ssef_peer u_peer (.sck(sck_in), .sdi(sdi), .sdo(sdo));
  task finish_test;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task chk_now(input logic [7:0] e, input logic [7:0] g);
    @(negedge clock);
    chk(e, g);
  endtask : chk_now
  task count_sck(input int n, output int r);
    logic prev;
    prev = sck_out;
    r = 0;
    repeat (n) begin
      @(negedge clock);
      if (sck_out && !prev) r++;
      prev = sck_out;
    end
  endtask : count_sck
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg
  task gap(input int n);
    repeat (n) @(posedge clock);
  endtask : gap
  always @(posedge clock) rd_seen <= rd;
  always @(negedge clock) if (rd_seen) chk(expq.pop_front(), rdata);
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] a, b, c;
    logic [7:0] r;
    int n_rise;
    void'($urandom(36));
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    gap(3);
    rst_n <= 1'b1;
    gap(3);
    rd_reg(8'h14, 8'h00);
    rd_reg(8'h20, 8'h00);
    wr_reg(8'h14, 8'h20);
    wr_reg(8'h13, 8'h5a);
    wr_reg(8'h13, 8'ha5);
    chk_now(8'h03, {6'h00, sck_oe, sdo_oe});
    gap(80);
    wr_reg(8'h13, 8'h3c);
    count_sck(80, n_rise);
    chk(8'h08, 8'(n_rise));
    rd_reg(8'h14, 8'ha0);
    rd_reg(8'h15, 8'h05);
    rd_reg(8'h13, 8'h00);
    wr_reg(8'h14, 8'h00);
    gap(3);
    chk_now(8'h00, {6'h00, sck_oe, sdo_oe});
    wr_reg(8'h16, 8'h02);
    wr_reg(8'h14, 8'h24);
    gap(3);
    chk_now(8'h01, {6'h00, sck_oe, sdo_oe});
    wr_reg(8'h13, c);
    u_peer.send(a, r);
    chk(c, r);
    gap(10);
    rd_reg(8'h15, 8'h01);
    rd_reg(8'h13, a);
    u_peer.send(b, r);
    chk(a, r);
    gap(10);
    u_peer.send(c, r);
    chk(b, r);
    gap(10);
    chk_now(8'h01, {7'h00, irq});
    rd_reg(8'h15, 8'h03);
    rd_reg(8'h13, b);
    rd_reg(8'h14, 8'h64);
    gap(3);
    chk_now(8'h00, {7'h00, irq});
    wr_reg(8'h14, 8'h24);
    rd_reg(8'h14, 8'h24);
    wr_reg(8'h14, 8'h26);
    u_peer.send(c, r);
    chk(8'h00, r);
    gap(10);
    u_peer.send(a, r);
    gap(10);
    rd_reg(8'h14, 8'h66);
    rd_reg(8'h13, c);
    gap(3);
    finish_test();
  end
endmodule : ssef_port_test
